// *** bench/apc_regs_tb.sv ***
`timescale 1ns/100ps
`include "apc_map.svh"

module apc_regs_tb;
  import apc_pkg::*;

  // -----
  // Stimulus and observed signals
  // -----
  logic                 clk_sys_in = 1'b0;
  logic                 rst_in = 1'b1;
  apc_req_s             req = '0;
  logic                 warn_n = 1'b1;
  logic                 binary = 1'b0;
  logic [1:0]           out_cfg = 2'h1;
  logic [23:0]          coef = 24'h123456;
  logic                 trig = 1'b0;
  logic                 svalid = 1'b0;
  logic [2:0][23:0]     samp = '0;
  logic                 vreq = 1'b0;
  logic                 zc = 1'b0;
  logic [7:0]           rd_data;
  logic                 rd_valid;
  logic [7:0]           coef_addr;
  logic                 pulse;
  logic [2:0]           mute;
  logic                 vapply;
  apc_proc_s            proc_cfg;
  apc_mod_s             mod_cfg;
  logic [1:0]           mode;
  logic [3:0]           psize;
  logic                 lim_act;
  logic [23:0]          lim_red;
  logic                 pcorr;
  logic                 pcorr_lo;
  int                   fail_count = 0;
  int                   n_checks = 0;

  always #2.5 clk_sys_in = ~clk_sys_in;

  apc_regs u_apc_regs (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_req_in(req),
    .rd_data_out(rd_data), .rd_valid_out(rd_valid),
    .overcurrent_warning_n_in(warn_n), .binary_mode_in(binary),
    .output_configuration_in(out_cfg), .coef_addr_out(coef_addr),
    .coef_rd_data_in(coef), .pulse_trigger_in(trig), .comp_pulse_out(pulse),
    .sample_valid_in(svalid), .sample_in(samp), .channel_mute_out(mute),
    .vol_change_req_in(vreq), .zero_cross_in(zc), .vol_apply_out(vapply),
    .proc_cfg_out(proc_cfg), .mod_cfg_out(mod_cfg), .output_stage_mode_out(mode),
    .comp_pulse_size_out(psize), .limit_adjust_active_out(lim_act),
    .limit_reduction_out(lim_red), .pcorr_active_out(pcorr),
    .pcorr_lineout_out(pcorr_lo)
  );

  // -----
  // Shared tasks
  // -----
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic do_reset();
    rst_in = 1'b1;
    repeat (16) @(negedge clk_sys_in);
    rst_in = 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_sys_in);
    req = '0;
    @(negedge clk_sys_in);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk_sys_in);
    req = '0;
    chk("rd_valid", 24'h1, {23'h0, rd_valid});
    chk("rd_data", {16'h0, exp}, {16'h0, rd_data});
    @(negedge clk_sys_in);
    chk("rd_valid_end", 24'h0, {23'h0, rd_valid});
  endtask

  task automatic wr_rd_chk(input logic [7:0] a, input logic [7:0] d);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_sys_in);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk_sys_in);
    req = '0;
    chk("wr_rd_data", {16'h0, d}, {16'h0, rd_data});
    @(negedge clk_sys_in);
  endtask

  // -----
  // Scenarios
  // -----
  task automatic t_reset_vals();
    rd_chk(`APC_ADDR_OUT_COMP, `APC_RST_OUT_COMP);
    rd_chk(`APC_ADDR_PROC, `APC_RST_PROC);
    rd_chk(`APC_ADDR_MOD, `APC_RST_MOD);
    rd_chk(8'h07, `APC_READ_UNMAPPED);
  endtask

  task automatic t_bits();
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      v = 8'h01 << i;
      wr(`APC_ADDR_PROC, v);
      wr(`APC_ADDR_MOD, ~v);
      chk("proc_cfg", {16'h0, v}, {16'h0, proc_cfg});
      chk("mod_cfg", {16'h0, ~v}, {16'h0, mod_cfg});
      rd_chk(`APC_ADDR_PROC, v);
      rd_chk(`APC_ADDR_MOD, ~v);
    end
    wr_rd_chk(`APC_ADDR_PROC, 8'ha5);
    wr(8'h09, 8'h55);
    wr(`APC_ADDR_OUT_COMP, 8'hff);
    rd_chk(`APC_ADDR_OUT_COMP, `APC_MASK_OUT_COMP);
    chk("mode_size", 24'h3f, {18'h0, mode, psize});
  endtask

  task automatic t_overcurrent();
    chk("coef_addr", {16'h0, `APC_COEF_ADDR_LIMIT}, {16'h0, coef_addr});
    wr(`APC_ADDR_OUT_COMP, 8'h1f);
    warn_n = 1'b0;
    repeat (4) @(negedge clk_sys_in);
    chk("lim_off", 24'h0, {23'h0, lim_act});
    warn_n = 1'b1;
    wr(`APC_ADDR_OUT_COMP, 8'h9f);
    warn_n = 1'b0;
    @(negedge clk_sys_in);
    warn_n = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    chk("lim_act", 24'h1, {23'h0, lim_act});
    chk("lim_red", coef, lim_red);
    do_reset();
    chk("lim_reset", 24'h0, {23'h0, lim_act});
  endtask

  task automatic pulse_case(input logic [1:0] m, input logic [3:0] s, input int exp);
    int cnt;
    cnt = 0;
    wr(`APC_ADDR_OUT_COMP, {2'b10, s, m});
    trig = 1'b1;
    @(negedge clk_sys_in);
    trig = 1'b0;
    repeat (70) begin
      if (pulse === 1'b1) cnt++;
      @(negedge clk_sys_in);
    end
    chk("pulse_len", exp, cnt);
  endtask

  task automatic t_pulse();
    pulse_case(`APC_MODE_VAR_DROP, 4'h1, `APC_TICK_CYCLES);
    pulse_case(`APC_MODE_VAR_DROP, 4'hf, `APC_PULSE_MAX_CYCLES);
    pulse_case(`APC_MODE_VAR_DROP, 4'h0, 0);
    pulse_case(`APC_MODE_TAPERED, 4'hf, 0);
  endtask

  task automatic t_zero_mute();
    samp = {24'h000100, 24'h0, 24'h0};
    svalid = 1'b1;
    repeat (`APC_ZERO_RUN - 1) @(negedge clk_sys_in);
    chk("mute_early", 24'h0, {21'h0, mute});
    @(negedge clk_sys_in);
    svalid = 1'b0;
    repeat (2) @(negedge clk_sys_in);
    chk("mute_on", 24'h3, {21'h0, mute});
    samp = {24'h0, 24'h0, 24'h000001};
    svalid = 1'b1;
    @(negedge clk_sys_in);
    svalid = 1'b0;
    repeat (2) @(negedge clk_sys_in);
    chk("mute_clear", 24'h2, {21'h0, mute});
    wr(`APC_ADDR_PROC, 8'h00);
    @(negedge clk_sys_in);
    chk("mute_off", 24'h0, {21'h0, mute});
  endtask

  task automatic vol_case(input logic [7:0] m, input logic zc_at, input int exp_wait);
    int cnt;
    cnt = 0;
    wr(`APC_ADDR_MOD, m);
    vreq = 1'b1;
    @(negedge clk_sys_in);
    vreq = 1'b0;
    repeat (4) begin
      if (vapply === 1'b1) cnt++;
      @(negedge clk_sys_in);
    end
    chk("vol_before_zc", exp_wait, cnt);
    zc = zc_at;
    @(negedge clk_sys_in);
    zc = 1'b0;
    repeat (3) begin
      if (vapply === 1'b1) cnt++;
      @(negedge clk_sys_in);
    end
    chk("vol_total", 24'h1, cnt);
  endtask

  task automatic t_volume();
    vol_case(8'hc2, 1'b1, 0);
    vol_case(8'h82, 1'b0, 1);
  endtask

  task automatic t_pcorr();
    logic [5:0] tb [5] = '{6'b1_11_0_01, 6'b1_11_0_00, 6'b1_01_0_01, 6'b1_11_1_01,
                           6'b0_11_0_01};
    logic e;
    foreach (tb[i]) begin
      {binary, out_cfg} = {tb[i][2], tb[i][1:0]};
      wr(`APC_ADDR_MOD, {6'h30, tb[i][5], 1'b0});
      wr(`APC_ADDR_OUT_COMP, {6'h27, tb[i][4:3]});
      @(negedge clk_sys_in);
      e = tb[i][5] && (tb[i][4:3] != `APC_MODE_TAPERED) && !tb[i][2];
      chk("pcorr", e, pcorr);
      chk("pcorr_lo", e && (tb[i][1:0] != `APC_OUTCFG_TWO_CH), pcorr_lo);
    end
  endtask

  task automatic summarize();
    $display("Checks: %0d mismatches: %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #200000;
    fail_count++;
    summarize();
  end

  initial begin
    do_reset();
    t_reset_vals();
    t_bits();
    t_overcurrent();
    t_pulse();
    t_zero_mute();
    t_volume();
    t_pcorr();
    summarize();
  end
endmodule

// *** hdl/apc_comp_pulse.sv ***
`timescale 1ns/100ps
`include "apc_map.svh"

module apc_comp_pulse (
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  // Settings
  input  wire logic [1:0] mode_in,
  input  wire logic [3:0] size_in,
  // Pulse
  input  wire logic       trigger_in,
  output logic            pulse_out
);
  import apc_pkg::*;

  localparam int TICK_CYC = `APC_TICK_CYCLES;
  localparam int MAX_CYC  = `APC_PULSE_MAX_CYCLES;
  localparam int CW       = $clog2(MAX_CYC + 1);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;

  // ---------------------------------------------------------------
  // Pulse length counter
  // ---------------------------------------------------------------
  always_comb begin
    next_cnt = cnt;
    if (cnt != '0) begin
      next_cnt = cnt - CW'(1);
    end else if (trigger_in && mode_in == `APC_MODE_VAR_DROP) begin
      next_cnt = CW'(int'(size_in) * TICK_CYC);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pulse_out <= 1'b0;
    end else begin
      pulse_out <= (next_cnt != '0);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [7:0] run;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      run <= 8'h00;
    end else begin
      run <= pulse_out ? run + 8'h01 : 8'h00;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  a_pulse_max_len: assert property (int'(run) <= MAX_CYC)
    else $error("compensating pulse longer than largest code");
  a_pulse_one_tick: assert property (
    (cnt == '0) && trigger_in && mode_in == `APC_MODE_VAR_DROP && size_in == 4'h1
    |=> pulse_out [*4] ##1 !pulse_out)
    else $error("one-tick pulse not four cycles");
  a_pulse_mode_gate: assert property (
    (cnt == '0) && trigger_in && mode_in != `APC_MODE_VAR_DROP |=> !pulse_out)
    else $error("pulse outside variable drop mode");
  c_pulse_full: cover property ((cnt == '0) && trigger_in && size_in == 4'hf
    && mode_in == `APC_MODE_VAR_DROP);
endmodule

// *** hdl/apc_map.svh ***
`ifndef APC_MAP_SVH
`define APC_MAP_SVH

// ---------------------------------------------------------------
// Register offsets on the control port
// ---------------------------------------------------------------
`define APC_ADDR_OUT_COMP 8'h02
`define APC_ADDR_PROC 8'h03
`define APC_ADDR_MOD 8'h04

// ---------------------------------------------------------------
// Reset values and writable masks
// ---------------------------------------------------------------
`define APC_RST_OUT_COMP 8'h9f
`define APC_RST_PROC 8'h40
`define APC_RST_MOD 8'hc2
`define APC_MASK_OUT_COMP 8'hbf
`define APC_READ_UNMAPPED 8'h00

// ---------------------------------------------------------------
// Mode and configuration codes
// ---------------------------------------------------------------
`define APC_MODE_VAR_DROP 2'h3
`define APC_MODE_TAPERED 2'h1
`define APC_OUTCFG_TWO_CH 2'h0
`define APC_OC_ADJUST_ON 1'b1

// ---------------------------------------------------------------
// Coefficient memory location of the limit reduction
// ---------------------------------------------------------------
`define APC_COEF_ADDR_LIMIT 8'h37

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define APC_CLK_NS 5
`define APC_TICK_NS 20
`define APC_PULSE_MAX_NS 300
`define APC_TICK_CYCLES ((`APC_TICK_NS + `APC_CLK_NS - 1) / `APC_CLK_NS)
`define APC_PULSE_MAX_CYCLES (`APC_PULSE_MAX_NS / `APC_CLK_NS)
`define APC_ZERO_RUN 2048

`endif

// *** hdl/apc_pkg.sv ***
package apc_pkg;

  // ---------------------------------------------------------------
  // Register layouts, bit 7 first
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       overcurrent_adjust_bypass;
    logic       reserved;
    logic [3:0] comp_pulse_size;
    logic [1:0] output_stage_mode;
  } apc_out_comp_s;

  typedef struct packed {
    logic submix_enable;
    logic zero_run_mute_enable;
    logic limiter_compression_mode;
    logic eq_coef_link;
    logic post_scale_link;
    logic eq_stage_bypass;
    logic deemphasis_enable;
    logic highpass_bypass;
  } apc_proc_s;

  typedef struct packed {
    logic soft_volume_enable;
    logic zero_cross_volume;
    logic distortion_comp_variable;
    logic modulator_rate_select;
    logic radio_band_noise_reduce;
    logic noise_shaper_order;
    logic max_power_correction;
    logic power_correction_coef_select;
  } apc_mod_s;

  // ---------------------------------------------------------------
  // Control port request
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } apc_req_s;

endpackage

// *** hdl/apc_regs.sv ***
// Function
// - Mode 11: pulse size from size field
// - Each size step adds one 20 ns tick
// - Warning low forces modulation limit reduction
// - Reduction stays latched until reset
// - Reduction amount from coefficient location 0x37
// - Bit 7 enables overcurrent adjustment, reset enabled
// - Processing bit 0 bypasses high-pass filter
// - Processing bit 1 enables de-emphasis
// - Processing bit 2 bypasses EQ stages
// - Processing bit 3 links post-scale to channel 1
// - Processing bit 4 links EQ coefficients
// - Processing bit 5 selects compression limiter mode
// - Bit 6 mutes channel after 2048 zeros
// - Processing bit 7 mixes sub into left/right
// - Modulator bit 0 selects programmable correction coefficient
// - Power correction off in tapered, binary; line-out correction also off in two-channel config
// - Modulator bit 2 selects third-order shaper
// - Modulator bit 3 selects radio-band noise mode
// - Modulator bit 4 selects 341.3 kHz rate
// - Modulator bit 5 selects programmable distortion coefficient
// - Bit 6 applies volume only at zero crossing
// - Mode code 11 is variable drop compensation
`timescale 1ns/100ps
`include "apc_map.svh"

module apc_regs #(
  parameter int CH     = 3,
  parameter int SAMP_W = 24,
  parameter int COEF_W = 24
) (
  // Clock and reset
  input  wire logic                         clk_sys_in,
  input  wire logic                         rst_in,
  // Control port
  input  wire apc_pkg::apc_req_s            reg_req_in,
  output logic      [7:0]                   rd_data_out,
  output logic                              rd_valid_out,
  // Power stage and output status
  input  wire logic                         overcurrent_warning_n_in,
  input  wire logic                         binary_mode_in,
  input  wire logic [1:0]                   output_configuration_in,
  // Coefficient memory
  output logic      [7:0]                   coef_addr_out,
  input  wire logic [COEF_W-1:0]            coef_rd_data_in,
  // Compensating pulse
  input  wire logic                         pulse_trigger_in,
  output logic                              comp_pulse_out,
  // Crossover samples and mute
  input  wire logic                         sample_valid_in,
  input  wire logic [CH-1:0][SAMP_W-1:0]    sample_in,
  output logic      [CH-1:0]                channel_mute_out,
  // Volume update
  input  wire logic                         vol_change_req_in,
  input  wire logic                         zero_cross_in,
  output logic                              vol_apply_out,
  // Configuration to the datapath
  output apc_pkg::apc_proc_s                proc_cfg_out,
  output apc_pkg::apc_mod_s                 mod_cfg_out,
  output logic      [1:0]                   output_stage_mode_out,
  output logic      [3:0]                   comp_pulse_size_out,
  // Limit adjustment and power correction
  output logic                              limit_adjust_active_out,
  output logic      [COEF_W-1:0]            limit_reduction_out,
  output logic                              pcorr_active_out,
  output logic                              pcorr_lineout_out
);
  import apc_pkg::*;

  apc_out_comp_s out_comp;
  logic          wr_out_comp;
  logic          wr_proc;
  logic          wr_mod;
  logic [7:0]    next_rd_data;
  logic          vol_pending;
  logic          next_vol_apply;
  logic          oc_adjust_enabled;

  assign wr_out_comp = reg_req_in.wr && (reg_req_in.addr == `APC_ADDR_OUT_COMP);
  assign wr_proc     = reg_req_in.wr && (reg_req_in.addr == `APC_ADDR_PROC);
  assign wr_mod      = reg_req_in.wr && (reg_req_in.addr == `APC_ADDR_MOD);

  // ---------------------------------------------------------------
  // Output compensation register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      out_comp <= apc_out_comp_s'(`APC_RST_OUT_COMP);
    end else if (wr_out_comp) begin
      // Reserved bit 6 never stores
      out_comp <= apc_out_comp_s'(reg_req_in.wdata & `APC_MASK_OUT_COMP);
    end
  end

  assign output_stage_mode_out = out_comp.output_stage_mode;
  assign comp_pulse_size_out   = out_comp.comp_pulse_size;
  assign oc_adjust_enabled     = (out_comp.overcurrent_adjust_bypass == `APC_OC_ADJUST_ON);

  // ---------------------------------------------------------------
  // Processing register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      proc_cfg_out <= apc_proc_s'(`APC_RST_PROC);
    end else if (wr_proc) begin
      // Filter, EQ, link, limiter, zero mute and submix controls
      proc_cfg_out <= apc_proc_s'(reg_req_in.wdata);
    end
  end

  // ---------------------------------------------------------------
  // Modulator register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      mod_cfg_out <= apc_mod_s'(`APC_RST_MOD);
    end else if (wr_mod) begin
      // Correction, shaper, radio band, rate, distortion, zero cross
      mod_cfg_out <= apc_mod_s'(reg_req_in.wdata);
    end
  end

  // ---------------------------------------------------------------
  // Read back
  // ---------------------------------------------------------------
  always_comb begin
    unique case (reg_req_in.addr)
      `APC_ADDR_OUT_COMP: next_rd_data = out_comp;
      `APC_ADDR_PROC:     next_rd_data = proc_cfg_out;
      `APC_ADDR_MOD:      next_rd_data = mod_cfg_out;
      default:            next_rd_data = `APC_READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      rd_data_out <= `APC_READ_UNMAPPED;
    end else if (reg_req_in.rd) begin
      rd_data_out <= next_rd_data;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= reg_req_in.rd;
    end
  end

  // ---------------------------------------------------------------
  // Overcurrent limit adjustment
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      limit_adjust_active_out <= 1'b0;
    end else if (oc_adjust_enabled && !overcurrent_warning_n_in) begin
      // Held until the next reset
      limit_adjust_active_out <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      coef_addr_out <= `APC_COEF_ADDR_LIMIT;
    end else begin
      coef_addr_out <= `APC_COEF_ADDR_LIMIT;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      limit_reduction_out <= '0;
    end else begin
      limit_reduction_out <= limit_adjust_active_out ? coef_rd_data_in : '0;
    end
  end

  // ---------------------------------------------------------------
  // Max power correction qualification
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pcorr_active_out <= 1'b0;
    end else begin
      pcorr_active_out <= mod_cfg_out.max_power_correction && !binary_mode_in
        && (out_comp.output_stage_mode != `APC_MODE_TAPERED);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pcorr_lineout_out <= 1'b0;
    end else begin
      pcorr_lineout_out <= mod_cfg_out.max_power_correction && !binary_mode_in
        && (out_comp.output_stage_mode != `APC_MODE_TAPERED)
        && (output_configuration_in != `APC_OUTCFG_TWO_CH);
    end
  end

  // ---------------------------------------------------------------
  // Zero-crossing volume update
  // ---------------------------------------------------------------
  always_comb begin
    if (mod_cfg_out.zero_cross_volume) begin
      next_vol_apply = (vol_pending || vol_change_req_in) && zero_cross_in;
    end else begin
      next_vol_apply = vol_change_req_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      vol_pending <= 1'b0;
    end else begin
      // A new request in the applying cycle is served by that same apply
      vol_pending <= (vol_pending || vol_change_req_in) && !next_vol_apply;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      vol_apply_out <= 1'b0;
    end else begin
      vol_apply_out <= next_vol_apply;
    end
  end

  // ---------------------------------------------------------------
  // Sub-blocks
  // ---------------------------------------------------------------
  apc_comp_pulse u_comp_pulse (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .mode_in    (out_comp.output_stage_mode),
    .size_in    (out_comp.comp_pulse_size),
    .trigger_in (pulse_trigger_in),
    .pulse_out  (comp_pulse_out)
  );

  apc_zero_mute #(
    .CH  (CH),
    .W   (SAMP_W),
    .RUN (`APC_ZERO_RUN)
  ) u_zero_mute (
    .clk_sys_in      (clk_sys_in),
    .rst_in          (rst_in),
    .enable_in       (proc_cfg_out.zero_run_mute_enable),
    .sample_valid_in (sample_valid_in),
    .sample_in       (sample_in),
    .mute_out        (channel_mute_out)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  a_reset_values: assert property (@(posedge clk_sys_in) disable iff (1'b0)
    rst_in |=> (proc_cfg_out == `APC_RST_PROC) && (mod_cfg_out == `APC_RST_MOD)
    && (out_comp == `APC_RST_OUT_COMP) && !limit_adjust_active_out)
    else $error("register not at reset value after reset");
  a_proc_read_back: assert property (
    wr_proc && !reg_req_in.rd ##1 reg_req_in.rd && reg_req_in.addr == `APC_ADDR_PROC
    && !reg_req_in.wr |=> rd_valid_out && rd_data_out == $past(reg_req_in.wdata, 2))
    else $error("processing register read back differs");
  a_reserved_zero: assert property (
    reg_req_in.rd && reg_req_in.addr == `APC_ADDR_OUT_COMP |=> !rd_data_out[6])
    else $error("reserved bit reads as one");
  a_oc_latch_set: assert property (
    oc_adjust_enabled && !overcurrent_warning_n_in |=> limit_adjust_active_out)
    else $error("overcurrent warning did not latch adjustment");
  a_oc_latch_hold: assert property (
    limit_adjust_active_out |=> limit_adjust_active_out)
    else $error("limit adjustment released without reset");
  a_oc_disabled: assert property (
    !limit_adjust_active_out && !oc_adjust_enabled |=> !limit_adjust_active_out)
    else $error("adjustment latched while disabled");
  a_limit_amount: assert property (
    limit_adjust_active_out |=> limit_reduction_out == $past(coef_rd_data_in)
    && coef_addr_out == `APC_COEF_ADDR_LIMIT)
    else $error("limit reduction not from coefficient location");
  a_pcorr_tapered: assert property (
    out_comp.output_stage_mode == `APC_MODE_TAPERED || binary_mode_in
    |=> !pcorr_active_out && !pcorr_lineout_out)
    else $error("power correction active in tapered or binary");
  a_pcorr_lineout: assert property (
    output_configuration_in == `APC_OUTCFG_TWO_CH |=> !pcorr_lineout_out)
    else $error("power correction touches line-out channels");
  a_pcorr_on: assert property (
    mod_cfg_out.max_power_correction && !binary_mode_in
    && out_comp.output_stage_mode != `APC_MODE_TAPERED |=> pcorr_active_out)
    else $error("power correction off although allowed");
  a_zcross_wait: assert property (
    mod_cfg_out.zero_cross_volume && !zero_cross_in |=> !vol_apply_out)
    else $error("volume applied away from zero crossing");
  a_vol_immediate: assert property (
    !mod_cfg_out.zero_cross_volume && vol_change_req_in |=> vol_apply_out)
    else $error("immediate volume change delayed");
  a_vol_pending: assert property (
    mod_cfg_out.zero_cross_volume && vol_pending && zero_cross_in
    |=> vol_apply_out)
    else $error("pending volume change missed zero crossing");

  a_proc_write: assert property (
    wr_proc
    |=> proc_cfg_out == $past(reg_req_in.wdata))
    else $error("processing register write lost");
  a_mod_write: assert property (
    wr_mod
    |=> mod_cfg_out == $past(reg_req_in.wdata))
    else $error("modulator register write lost");
  a_comp_write: assert property (
    wr_out_comp
    |=> out_comp == ($past(reg_req_in.wdata) & `APC_MASK_OUT_COMP))
    else $error("compensation register write lost");
  a_proc_hold: assert property (
    !wr_proc
    |=> $stable(proc_cfg_out))
    else $error("processing register changed without write");
  a_mod_hold: assert property (
    !wr_mod
    |=> $stable(mod_cfg_out))
    else $error("modulator register changed without write");
  a_rd_valid_set: assert property (
    reg_req_in.rd
    |=> rd_valid_out)
    else $error("read not acknowledged");
  a_rd_valid_clear: assert property (
    !reg_req_in.rd
    |=> !rd_valid_out)
    else $error("read valid without read");
  a_rd_unmapped: assert property (
    reg_req_in.rd && reg_req_in.addr != `APC_ADDR_OUT_COMP && reg_req_in.addr != `APC_ADDR_PROC
    && reg_req_in.addr != `APC_ADDR_MOD |=> rd_data_out == `APC_READ_UNMAPPED)
    else $error("unmapped address reads nonzero");
  a_coef_addr_fixed: assert property (coef_addr_out == `APC_COEF_ADDR_LIMIT)
    else $error("coefficient address moved");
  a_limit_idle: assert property (
    !limit_adjust_active_out
    |=> limit_reduction_out == '0)
    else $error("limit reduction without latched warning");

  c_oc_latched: cover property ($rose(limit_adjust_active_out));
  c_vol_deferred: cover property (mod_cfg_out.zero_cross_volume && vol_change_req_in
    && !zero_cross_in ##[1:8] vol_apply_out);
  c_mod_written: cover property (wr_mod ##1 mod_cfg_out.modulator_rate_select);
endmodule

// *** hdl/apc_zero_mute.sv ***
`timescale 1ns/100ps
`include "apc_map.svh"

module apc_zero_mute #(
  parameter int CH  = 3,
  parameter int W   = 24,
  parameter int RUN = `APC_ZERO_RUN
) (
  // Clock and reset
  input  wire logic                 clk_sys_in,
  input  wire logic                 rst_in,
  // Control
  input  wire logic                 enable_in,
  // Crossover output samples
  input  wire logic                 sample_valid_in,
  input  wire logic [CH-1:0][W-1:0] sample_in,
  // Mute per channel
  output logic      [CH-1:0]        mute_out
);
  import apc_pkg::*;

  localparam int CW = $clog2(RUN + 1);

  // ---------------------------------------------------------------
  // Zero run counter per channel
  // ---------------------------------------------------------------
  for (genvar c = 0; c < CH; c++) begin : g_ch
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;

    always_comb begin
      next_cnt = cnt;
      if (sample_valid_in) begin
        if (sample_in[c] != '0) begin
          next_cnt = '0;
        end else if (cnt != CW'(RUN)) begin
          next_cnt = cnt + CW'(1);
        end
      end
    end

    always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
        cnt <= '0;
      end else begin
        cnt <= next_cnt;
      end
    end

    always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
        mute_out[c] <= 1'b0;
      end else begin
        mute_out[c] <= enable_in && (next_cnt == CW'(RUN));
      end
    end

    a_mute_nonzero: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      sample_valid_in && sample_in[c] != '0 |=> !mute_out[c])
      else $error("channel muted after nonzero sample");
    a_mute_enable: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !enable_in |=> !mute_out[c])
      else $error("channel muted while zero mute disabled");
  end

  c_mute_seen: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    $rose(mute_out[0]));
endmodule
